// ---- hw/spm_master_regs.sv ----
// Memory-backed serial master: Wishbone registers, transfer engine, interrupt
// Assumes a byte-wide memory port answering with a one-cycle ack on core_clk
// Notes on behaviour
// - Writing one to a disable bit clears that event's interrupt enable.
// - Reading the disable register returns the current enable bits.
// - Rate code selects 125 kbps up to 4 Mbps, doubling per code bit; the 8 Mbps code is held at a 13-cycle period.
// - Serial clock is divided down from the core clock.
// - Receive limit bounds bytes written into receive memory.
// - Receive moved count reports bytes stored in the last transaction.
// - Transmit limit bounds bytes read; software keeps it 1 to 0x7fff.
// - Writing one to a set bit enables that interrupt; reads share state.
// - Both-done event fires only after both buffers reach their end.
// - Past the transmit limit the over-read character is shifted out.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_master_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic spi_sck_o,
    output logic spi_out_data_o,
    input wire logic spi_in_data_i,
    output logic [31:0] clk_pin_sel_o,
    output logic [31:0] out_pin_sel_o,
    output logic [31:0] in_pin_sel_o,
    output logic dma_req_o,
    output logic dma_we_o,
    output logic [31:0] dma_adr_o,
    output logic [7:0] dma_dat_o,
    input wire logic [7:0] dma_dat_i,
    input wire logic dma_ack_i
);
    spm_byte_if bif ();

    logic ack_q;
    logic [31:0] rd_q;
    logic [31:0] rd_d;
    logic [`SPM_EV_W-1:0] ien_q;
    logic [`SPM_EV_W-1:0] st_q;
    logic [31:0] enable_q;
    logic [31:0] psel_clk_q;
    logic [31:0] psel_out_q;
    logic [31:0] psel_in_q;
    logic [31:0] rate_q;
    logic [31:0] rx_ptr_q;
    logic [`SPM_LIM_W-1:0] rx_lim_q;
    logic [`SPM_LIM_W-1:0] rx_moved_q;
    logic [`SPM_LIST_W-1:0] rx_list_q;
    logic [31:0] tx_ptr_q;
    logic [`SPM_LIM_W-1:0] tx_lim_q;
    logic [`SPM_LIM_W-1:0] tx_moved_q;
    logic [`SPM_LIST_W-1:0] tx_list_q;
    logic [7:0] orc_q;
    logic [7:0] byte_q;
    logic go_q;
    logic stop_q;
    logic miso_s1_q;
    logic miso_s2_q;
    logic [`SPM_LIM_W-1:0] idx_q;
    logic [`SPM_LIM_W-1:0] idx_d;
    spm_pkg::spm_state_type st_state_q;
    spm_pkg::spm_state_type st_state_d;
    logic go_d;
    logic [`SPM_EV_W-1:0] ev;

    // Byte-lane merge for read-write registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // Smaller of a byte count and a limit
    function automatic logic [`SPM_LIM_W-1:0] cap(input logic [`SPM_LIM_W-1:0] n, input logic [`SPM_LIM_W-1:0] lim);
        cap = (n < lim) ? n : lim;
    endfunction

    // Code to serial clock period in core cycles; unknown codes run at 250 kbps
    function automatic spm_pkg::spm_period_type rate_period(input logic [31:0] code);
        logic [2:0] n;
        logic [9:0] p;
        n = 3'h1;
        case (code)
            `SPM_RATE_125K: n = 3'h0;
            `SPM_RATE_250K: n = 3'h1;
            `SPM_RATE_500K: n = 3'h2;
            `SPM_RATE_1M: n = 3'h3;
            `SPM_RATE_2M: n = 3'h4;
            `SPM_RATE_4M: n = 3'h5;
            `SPM_RATE_8M: n = 3'h6;
            default: n = 3'h1;
        endcase
        p = 10'(`SPM_SLOW_PERIOD_CYC >> n);
        // Fastest code would undercut the least clock period, so hold it there
        rate_period = (p < 10'(`SPM_MIN_PERIOD_CYC)) ? 10'(`SPM_MIN_PERIOD_CYC) : p;
    endfunction

    // Bus decode
    wire [11:0] adr = {wb_adr_i[11:2], 2'b00};
    wire req = wb_cyc_i && wb_stb_i;
    wire wr = req && wb_we_i && ack_q;
    wire [4:0] wmask = wb_dat_i[4:0] & {5{wb_sel_i[0]}};
    wire wr_intset = wr && adr == `SPM_ADR_INT_SET;
    wire wr_intclr = wr && adr == `SPM_ADR_INT_DISABLE;
    wire wr_evclr = wr && adr == `SPM_ADR_EV_CLEAR;
    wire start_wr = wr && adr == `SPM_ADR_TASK_START && wmask[0];
    wire stop_wr = wr && adr == `SPM_ADR_TASK_STOP && wmask[0];
    wire busy = st_state_q != spm_pkg::ST_IDLE;

    // Engine decode
    wire [`SPM_LIM_W-1:0] idx1 = idx_q + 15'h0001;
    wire [`SPM_LIM_W-1:0] total = (rx_lim_q > tx_lim_q) ? rx_lim_q : tx_lim_q;
    wire need_tx = idx_q < tx_lim_q;
    wire need_rx = idx_q < rx_lim_q;
    wire start_go = start_wr && enable_q != `SPM_RST_ZERO && !busy;
    wire stop_pend = stop_q || stop_wr;
    wire in_idle = st_state_q == spm_pkg::ST_IDLE;
    wire in_fetch = st_state_q == spm_pkg::ST_FETCH;
    wire in_shift = st_state_q == spm_pkg::ST_SHIFT;
    wire in_store = st_state_q == spm_pkg::ST_STORE;
    wire fetch_ok = in_fetch && (!need_tx || dma_ack_i);
    wire byte_end = (in_shift && bif.done && !need_rx) || (in_store && dma_ack_i);
    wire fin_ok = (in_idle && start_go && total == 15'h0000) || (byte_end && !stop_pend && idx1 == total);
    wire fin_stop = (byte_end && stop_pend) || (in_idle && stop_wr && !start_go);
    wire [`SPM_LIM_W-1:0] fin_cnt = byte_end ? idx1 : 15'h0000;
    wire save_cnt = fin_ok || (fin_stop && byte_end);

    // Event pulses
    assign ev[`SPM_EV_HALT] = fin_stop;
    assign ev[`SPM_EV_BOTH] = fin_ok;
    assign ev[`SPM_EV_BEGUN] = in_idle && start_go;
    assign ev[`SPM_EV_TXDONE] = (in_shift && bif.done && idx1 == tx_lim_q) || (fin_ok && tx_lim_q == 15'h0000);
    assign ev[`SPM_EV_RXDONE] = (in_store && dma_ack_i && idx1 == rx_lim_q) || (fin_ok && rx_lim_q == 15'h0000);

    // Memory port: reads stay under the transmit limit, writes under the receive limit
    assign dma_req_o = (in_fetch && need_tx) || in_store;
    assign dma_we_o = in_store;
    assign dma_adr_o = in_store ? rx_ptr_q + 32'(idx_q) : tx_ptr_q + 32'(idx_q);
    assign dma_dat_o = bif.rx_byte;

    // Shifter hookup
    assign bif.start = go_q;
    assign bif.tx_byte = byte_q;
    assign bif.period = rate_period(rate_q);
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;
    assign irq_o = |(st_q & ien_q);
    assign clk_pin_sel_o = psel_clk_q;
    assign out_pin_sel_o = psel_out_q;
    assign in_pin_sel_o = psel_in_q;

    spm_shifter u_shift (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_data(miso_s2_q),
        .sck(spi_sck_o),
        .out_data(spi_out_data_o),
        .bif(bif)
    );

    // Read mux
    always_comb begin
        rd_d = `SPM_RST_ZERO;
        case (adr)
            `SPM_ADR_EV_STATUS: rd_d = 32'(st_q);
            `SPM_ADR_INT_SET: rd_d = 32'(ien_q);
            `SPM_ADR_INT_DISABLE: rd_d = 32'(ien_q);
            `SPM_ADR_ENABLE: rd_d = enable_q;
            `SPM_ADR_PSEL_CLK: rd_d = psel_clk_q;
            `SPM_ADR_PSEL_OUT: rd_d = psel_out_q;
            `SPM_ADR_PSEL_IN: rd_d = psel_in_q;
            `SPM_ADR_RATE: rd_d = rate_q;
            `SPM_ADR_RX_PTR: rd_d = rx_ptr_q;
            `SPM_ADR_RX_LIM: rd_d = 32'(rx_lim_q);
            `SPM_ADR_RX_MOVED: rd_d = 32'(rx_moved_q);
            `SPM_ADR_RX_LIST: rd_d = 32'(rx_list_q);
            `SPM_ADR_TX_PTR: rd_d = tx_ptr_q;
            `SPM_ADR_TX_LIM: rd_d = 32'(tx_lim_q);
            `SPM_ADR_TX_MOVED: rd_d = 32'(tx_moved_q);
            `SPM_ADR_TX_LIST: rd_d = 32'(tx_list_q);
            `SPM_ADR_ORC: rd_d = 32'(orc_q);
            default: rd_d = `SPM_RST_ZERO;
        endcase
    end

    // Transfer sequencing
    always_comb begin
        st_state_d = st_state_q;
        idx_d = idx_q;
        go_d = 1'b0;
        case (st_state_q)
            spm_pkg::ST_IDLE: begin
                if (start_go && total != 15'h0000) begin
                    st_state_d = spm_pkg::ST_FETCH;
                    idx_d = 15'h0000;
                end
            end
            spm_pkg::ST_FETCH: begin
                if (fetch_ok) begin
                    st_state_d = spm_pkg::ST_SHIFT;
                    go_d = 1'b1;
                end
            end
            spm_pkg::ST_SHIFT: begin
                if (bif.done) begin
                    st_state_d = need_rx ? spm_pkg::ST_STORE : spm_pkg::ST_FETCH;
                end
            end
            spm_pkg::ST_STORE: begin
                if (dma_ack_i) begin
                    st_state_d = spm_pkg::ST_FETCH;
                end
            end
            default: st_state_d = spm_pkg::ST_IDLE;
        endcase
        if (byte_end) begin
            idx_d = idx1;
            if (fin_ok || fin_stop) begin
                st_state_d = spm_pkg::ST_IDLE;
            end
        end
    end

    // Bus answer one cycle after the request; dropped the cycle after
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rd_q <= `SPM_RST_ZERO;
        end else begin
            ack_q <= req && !ack_q;
            if (req && !ack_q) begin
                rd_q <= rd_d;
            end
        end
    end

    // Enables, and sticky status where a new event beats a clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ien_q <= 5'h00;
            st_q <= 5'h00;
        end else begin
            if (wr_intset) begin
                ien_q <= ien_q | wmask;
            end else if (wr_intclr) begin
                ien_q <= ien_q & ~wmask;
            end
            st_q <= (st_q & ~(wr_evclr ? wmask : 5'h00)) | ev;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= `SPM_RST_ZERO;
            psel_clk_q <= `SPM_RST_ZERO;
            psel_out_q <= `SPM_RST_ZERO;
            psel_in_q <= `SPM_RST_ZERO;
            rate_q <= `SPM_RST_RATE;
            rx_ptr_q <= `SPM_RST_ZERO;
            rx_lim_q <= 15'h0000;
            rx_list_q <= 2'h0;
            tx_ptr_q <= `SPM_RST_ZERO;
            tx_lim_q <= 15'h0000;
            tx_list_q <= 2'h0;
            orc_q <= 8'h00;
        end else if (wr) begin
            case (adr)
                `SPM_ADR_ENABLE: enable_q <= merge(enable_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_PSEL_CLK: psel_clk_q <= merge(psel_clk_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_PSEL_OUT: psel_out_q <= merge(psel_out_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_PSEL_IN: psel_in_q <= merge(psel_in_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_RATE: rate_q <= merge(rate_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_RX_PTR: rx_ptr_q <= merge(rx_ptr_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_RX_LIM: rx_lim_q <= 15'(merge(32'(rx_lim_q), wb_dat_i, wb_sel_i));
                `SPM_ADR_RX_LIST: rx_list_q <= 2'(merge(32'(rx_list_q), wb_dat_i, wb_sel_i));
                `SPM_ADR_TX_PTR: tx_ptr_q <= merge(tx_ptr_q, wb_dat_i, wb_sel_i);
                `SPM_ADR_TX_LIM: tx_lim_q <= 15'(merge(32'(tx_lim_q), wb_dat_i, wb_sel_i));
                `SPM_ADR_TX_LIST: tx_list_q <= 2'(merge(32'(tx_list_q), wb_dat_i, wb_sel_i));
                `SPM_ADR_ORC: orc_q <= 8'(merge(32'(orc_q), wb_dat_i, wb_sel_i));
                default: orc_q <= orc_q;
            endcase
        end
    end

    // Engine state; limits may change mid-transfer, which software must avoid
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_state_q <= spm_pkg::ST_IDLE;
            idx_q <= 15'h0000;
            go_q <= 1'b0;
            stop_q <= 1'b0;
            byte_q <= 8'h00;
            rx_moved_q <= 15'h0000;
            tx_moved_q <= 15'h0000;
        end else begin
            st_state_q <= st_state_d;
            idx_q <= idx_d;
            go_q <= go_d;
            stop_q <= (stop_q || (stop_wr && busy)) && !(fin_ok || fin_stop);
            if (fetch_ok) begin
                byte_q <= need_tx ? dma_dat_i : orc_q;
            end
            if (save_cnt) begin
                rx_moved_q <= cap(fin_cnt, rx_lim_q);
                tx_moved_q <= cap(fin_cnt, tx_lim_q);
            end
        end
    end

    // In-data pin synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            miso_s1_q <= spi_in_data_i;
            miso_s2_q <= miso_s1_q;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_IEN_CLR: assert property (wr_intclr && wmask[0] |=> !ien_q[0])
        else $error("disable write left enable set");
    AST_IEN_KEEP: assert property (wr_intclr && !wmask[1] |=> ien_q[1] == $past(ien_q[1]))
        else $error("zero disable bit changed enable");
    AST_CLR_READ: assert property (req && !ack_q && adr == `SPM_ADR_INT_DISABLE |=> rd_q[4:0] == $past(ien_q))
        else $error("disable read does not show enables");
    AST_RATE_1M: assert property (rate_q == `SPM_RATE_1M |-> bif.period == 10'h064)
        else $error("1 Mbps code gives wrong period");
    AST_RX_BOUND: assert property (dma_req_o && dma_we_o |-> idx_q < rx_lim_q)
        else $error("receive write beyond limit");
    AST_RX_MOVED: assert property (fin_ok |=> rx_moved_q == $past(rx_lim_q))
        else $error("receive moved count wrong");
    AST_TX_BOUND: assert property (dma_req_o && !dma_we_o |-> idx_q < tx_lim_q)
        else $error("transmit read beyond limit");
    AST_IEN_SET: assert property (wr_intset && wmask[2] |=> ien_q[2])
        else $error("set write left enable clear");
    AST_BOTH: assert property (ev[`SPM_EV_BOTH] |-> fin_cnt >= rx_lim_q && fin_cnt >= tx_lim_q)
        else $error("both-done before both buffers ended");
    AST_ORC: assert property (go_q && !need_tx |-> byte_q == orc_q)
        else $error("over-read character not sent");
    AST_IRQ: assert property (|(ev & ien_q) && !wr_intclr |=> irq_o)
        else $error("enabled event gave no interrupt");
endmodule

// ---- hw/spm_defines.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes a 100 MHz core clock and a 12-bit Wishbone byte address
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
`define SPM_ADR_TASK_START 12'h010
`define SPM_ADR_TASK_STOP 12'h014
`define SPM_ADR_EV_STATUS 12'h100
`define SPM_ADR_EV_CLEAR 12'h104
`define SPM_ADR_INT_SET 12'h304
`define SPM_ADR_INT_DISABLE 12'h308
`define SPM_ADR_ENABLE 12'h500
`define SPM_ADR_PSEL_CLK 12'h508
`define SPM_ADR_PSEL_OUT 12'h50C
`define SPM_ADR_PSEL_IN 12'h510
`define SPM_ADR_RATE 12'h524
`define SPM_ADR_RX_PTR 12'h534
`define SPM_ADR_RX_LIM 12'h538
`define SPM_ADR_RX_MOVED 12'h53C
`define SPM_ADR_RX_LIST 12'h540
`define SPM_ADR_TX_PTR 12'h544
`define SPM_ADR_TX_LIM 12'h548
`define SPM_ADR_TX_MOVED 12'h54C
`define SPM_ADR_TX_LIST 12'h550
`define SPM_ADR_ORC 12'h5C0
// Event bit positions, shared by status, clear and enable registers
`define SPM_EV_HALT 0
`define SPM_EV_RXDONE 1
`define SPM_EV_BOTH 2
`define SPM_EV_TXDONE 3
`define SPM_EV_BEGUN 4
`define SPM_EV_W 5
`define SPM_LIM_W 15
`define SPM_LIST_W 2
// Rate codes
`define SPM_RATE_125K 32'h02000000
`define SPM_RATE_250K 32'h04000000
`define SPM_RATE_500K 32'h08000000
`define SPM_RATE_1M 32'h10000000
`define SPM_RATE_2M 32'h20000000
`define SPM_RATE_4M 32'h40000000
`define SPM_RATE_8M 32'h80000000
`define SPM_RST_RATE `SPM_RATE_250K
`define SPM_RST_ZERO 32'h00000000
// Timing
`define SPM_CLK_KHZ 100000
`define SPM_CLK_NS 10
`define SPM_SLOW_KBPS 125
`define SPM_SLOW_PERIOD_CYC (`SPM_CLK_KHZ / `SPM_SLOW_KBPS)
`define SPM_MIN_SCK_NS 125
`define SPM_MIN_PERIOD_CYC ((`SPM_MIN_SCK_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`endif

// ---- hw/spm_pkg.sv ----
// Types shared by the serial master files
// Assumes spm_defines.svh supplies all numeric constants
package spm_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_SHIFT = 4'h4,
        ST_STORE = 4'h8
    } spm_state_type;
    typedef logic [9:0] spm_period_type;
endpackage

// ---- hw/spm_byte_if.sv ----
// Byte hand-over between transfer engine and serial shifter
// Assumes both ends run on core_clk
`timescale 1ns/1ps
interface spm_byte_if;
    logic start;
    logic [7:0] tx_byte;
    spm_pkg::spm_period_type period;
    logic done;
    logic [7:0] rx_byte;
    modport ctrl (output start, output tx_byte, output period, input done, input rx_byte);
    modport shft (input start, input tx_byte, input period, output done, output rx_byte);
endinterface

// ---- hw/spm_shifter.sv ----
// Serial byte shifter, mode 0, most significant bit first
// Assumes the in-data line is already synchronised to core_clk
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_shifter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_data,
    output logic sck,
    output logic out_data,
    spm_byte_if.shft bif
);
    logic [9:0] cnt_q;
    logic [2:0] bit_q;
    logic busy_q;
    logic [7:0] sh_q;
    logic [7:0] rx_q;
    logic done_q;
    wire [9:0] half = {1'b0, bif.period[9:1]};
    wire rise_now = busy_q && (cnt_q == half - 10'h001);
    wire fall_now = busy_q && (cnt_q == bif.period - 10'h001);

    assign bif.done = done_q;
    assign bif.rx_byte = rx_q;

    // Clock period counted in core cycles, so rate tracks core clock accuracy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 10'h000;
            bit_q <= 3'h0;
            busy_q <= 1'b0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            done_q <= 1'b0;
            sck <= 1'b0;
            out_data <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q && bif.start) begin
                busy_q <= 1'b1;
                sh_q <= bif.tx_byte;
                out_data <= bif.tx_byte[7];
                cnt_q <= 10'h000;
                bit_q <= 3'h0;
            end else if (busy_q) begin
                cnt_q <= fall_now ? 10'h000 : cnt_q + 10'h001;
                if (rise_now) begin
                    sck <= 1'b1;
                    sh_q <= {sh_q[6:0], in_data}; // Sample on leading edge
                end
                if (fall_now) begin
                    sck <= 1'b0;
                    bit_q <= bit_q + 3'h1;
                    out_data <= sh_q[7];
                    if (bit_q == 3'h7) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        rx_q <= sh_q;
                    end
                end
            end
        end
    end
endmodule

// ---- testbench/spm_partner.sv ----
// Far side model: mode 0 serial slave plus byte memory on the engine port
// Assumes the memory port shares core_clk and the slave is always selected
`timescale 1ns/1ps
module spm_partner (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic out_data,
    output logic in_data,
    input wire logic dma_req,
    input wire logic dma_we,
    input wire logic [31:0] dma_adr,
    input wire logic [7:0] dma_wdat,
    output logic [7:0] dma_rdat,
    output logic dma_ack
);
    logic [7:0] pat_q = 8'hC3;
    logic [7:0] sh_q = 8'h00;
    logic [7:0] got [0:7];
    logic [7:0] mem [0:255];
    int nbit = 0;
    int ngot = 0;
    int nstore = 0;
    int dly = 0;
    // Known fill so untouched bytes can be told apart
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'hEE;
    end
    // Slave moves its data on the fall, so it is steady at the rise
    assign in_data = pat_q[7];
    // Reset takes sck from unknown to low, a false fall that must not rotate
    always @(negedge sck) if (rst_n) pat_q <= {pat_q[6:0], pat_q[7]};
    // Master data captured MSB first, one byte per eight rises
    always @(posedge sck) begin
        sh_q = {sh_q[6:0], out_data};
        nbit++;
        if (nbit % 8 == 0) begin
            got[ngot] = sh_q;
            ngot++;
        end
    end
    // Slow memory; read data churns outside the ack cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_ack <= 1'b0;
            dma_rdat <= 8'h00;
        end else begin
            dma_ack <= 1'b0;
            dma_rdat <= ~dma_rdat;
            if (dma_req && !dma_ack) begin
                if (dly == 2) begin
                    dma_ack <= 1'b1;
                    dly = 0;
                    if (dma_we) begin
                        mem[dma_adr[7:0]] <= dma_wdat;
                        nstore++;
                    end else begin
                        dma_rdat <= dma_adr[7:0] ^ 8'h5A;
                    end
                end else begin
                    dly++;
                end
            end
        end
    end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the serial master register block
// Assumes spm_partner stands at the far side and core_clk runs at 100 MHz
`timescale 1ns/1ps
`include "spm_defines.svh"
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h00000000;
    logic ack, irq, sck, sdo, sdi, dreq, dwe, dack;
    logic [31:0] rdat, dadr, cpin, opin, ipin, q;
    logic [7:0] dwdat, drdat;
    logic sck_d = 1'b0;
    int per = 0;
    int cnt = 0;
    int bad_count = 0;
    int compares = 0;
    logic [31:0] codes [7] = '{`SPM_RATE_125K, `SPM_RATE_250K, `SPM_RATE_500K, `SPM_RATE_1M,
        `SPM_RATE_2M, `SPM_RATE_4M, `SPM_RATE_8M};
    always #5 core_clk = ~core_clk;
    spm_master_regs spm_master_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .spi_sck_o(sck), .spi_out_data_o(sdo), .spi_in_data_i(sdi), .clk_pin_sel_o(cpin),
        .out_pin_sel_o(opin), .in_pin_sel_o(ipin), .dma_req_o(dreq), .dma_we_o(dwe), .dma_adr_o(dadr),
        .dma_dat_o(dwdat), .dma_dat_i(drdat), .dma_ack_i(dack));
    spm_partner spm_partner_inst (.core_clk(core_clk), .rst_n(rst_n), .sck(sck), .out_data(sdo),
        .in_data(sdi), .dma_req(dreq), .dma_we(dwe), .dma_adr(dadr), .dma_wdat(dwdat),
        .dma_rdat(drdat), .dma_ack(dack));
    // Cycles between serial clock rises, to see the divider at work
    always @(posedge core_clk) begin
        sck_d <= sck;
        cnt <= cnt + 1;
        if (sck && !sck_d) begin
            per <= cnt;
            cnt <= 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle; returns off the edge so register effects have landed
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask
    // Polls status until both buffers are done; the watchdog covers a hang
    task automatic wait_done;
        q = 32'h00000000;
        while (q[`SPM_EV_BOTH] !== 1'b1) wb(1'b0, `SPM_ADR_EV_STATUS, 32'h00000000);
    endtask
    task automatic xfer(input logic [31:0] txp, input logic [31:0] txl, input logic [31:0] rxp,
        input logic [31:0] rxl);
        wr(`SPM_ADR_TX_PTR, txp);
        wr(`SPM_ADR_TX_LIM, txl);
        wr(`SPM_ADR_RX_PTR, rxp);
        wr(`SPM_ADR_RX_LIM, rxl);
        wr(`SPM_ADR_TASK_START, 32'h00000001);
        wait_done();
        rd(`SPM_ADR_EV_STATUS, 32'h0000001E);
        rd(`SPM_ADR_RX_MOVED, rxl);
    endtask
    task automatic wrap_up;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Whole run needs a few thousand cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`SPM_ADR_RATE, `SPM_RST_RATE);
        rd(`SPM_ADR_INT_DISABLE, 32'h00000000);
        rd(`SPM_ADR_RX_MOVED, 32'h00000000);
        rd(12'h600, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        $display("test reset done");
        wr(`SPM_ADR_INT_SET, 32'h0000001F);
        rd(`SPM_ADR_INT_DISABLE, 32'h0000001F);
        wr(`SPM_ADR_INT_DISABLE, 32'h00000005);
        rd(`SPM_ADR_INT_SET, 32'h0000001A);
        wr(`SPM_ADR_INT_DISABLE, 32'h00000000);
        rd(`SPM_ADR_INT_DISABLE, 32'h0000001A);
        wr(`SPM_ADR_INT_DISABLE, 32'h0000001F);
        rd(`SPM_ADR_INT_SET, 32'h00000000);
        // Stop while idle only raises the halted event
        wr(`SPM_ADR_TASK_STOP, 32'h00000001);
        rd(`SPM_ADR_EV_STATUS, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
        wr(`SPM_ADR_EV_CLEAR, 32'h0000001F);
        rd(`SPM_ADR_EV_STATUS, 32'h00000000);
        $display("test enables done");
        // Last code left in place is the fastest
        foreach (codes[i]) begin
            wr(`SPM_ADR_RATE, codes[i]);
            rd(`SPM_ADR_RATE, codes[i]);
        end
        wr(`SPM_ADR_PSEL_CLK, 32'h0000000B);
        chk(cpin, 32'h0000000B);
        wr(`SPM_ADR_PSEL_OUT, 32'h0000000C);
        chk(opin, 32'h0000000C);
        wr(`SPM_ADR_PSEL_IN, 32'h0000000D);
        chk(ipin, 32'h0000000D);
        rd(`SPM_ADR_PSEL_IN, 32'h0000000D);
        wr(`SPM_ADR_ENABLE, 32'h00000007);
        wr(`SPM_ADR_ORC, 32'h0000007E);
        wr(`SPM_ADR_INT_SET, 32'h00000004);
        // Receive longer than transmit: the tail byte is the filler
        xfer(32'h20, 32'h2, 32'h40, 32'h3);
        chk(32'(per), 32'h0000000D);
        chk({24'h0, spm_partner_inst.got[0]}, 32'h7A);
        chk({24'h0, spm_partner_inst.got[1]}, 32'h7B);
        chk({24'h0, spm_partner_inst.got[2]}, 32'h7E);
        chk({24'h0, spm_partner_inst.mem[8'h42]}, 32'hC3);
        chk({31'h0, irq}, 32'h00000001);
        wr(`SPM_ADR_INT_DISABLE, 32'h00000004);
        chk({31'h0, irq}, 32'h00000000);
        wr(`SPM_ADR_INT_SET, 32'h00000004);
        chk({31'h0, irq}, 32'h00000001);
        wr(`SPM_ADR_EV_CLEAR, 32'h0000001F);
        chk({31'h0, irq}, 32'h00000000);
        $display("test long receive done");
        // Receive shorter than transmit at 1 Mbps
        wr(`SPM_ADR_RATE, `SPM_RATE_1M);
        xfer(32'h30, 32'h2, 32'h60, 32'h1);
        chk(32'(per), 32'h00000064);
        chk(32'(spm_partner_inst.nstore), 32'h00000004);
        chk({24'h0, spm_partner_inst.mem[8'h61]}, 32'hEE);
        chk(32'(spm_partner_inst.ngot), 32'h00000005);
        rd(`SPM_ADR_TX_MOVED, 32'h00000002);
        chk({24'h0, spm_partner_inst.got[4]}, 32'h6B);
        $display("test short receive done");
        wrap_up();
    end
endmodule
